// >>> design/tca_defs.svh
// Constants for the temperature conversion and alarm core
`ifndef TCA_DEFS_SVH
`define TCA_DEFS_SVH

// Bus commands, sent least significant bit first
`define TCA_CMD_SKIP_ADDR 8'hcc
`define TCA_CMD_ALARM_SCAN 8'hec
`define TCA_CMD_CONVERT 8'h44
`define TCA_CMD_SUPPLY_QUERY 8'hb4
`define TCA_CMD_READ_SCRATCH 8'hbe
`define TCA_CMD_WRITE_SCRATCH 8'h4e
`define TCA_CMD_COMMIT_NV 8'h48

// Scratchpad byte positions
`define TCA_SCR_TEMP_LO 4'h0
`define TCA_SCR_TEMP_HI 4'h1
`define TCA_SCR_UPPER 4'h2
`define TCA_SCR_LOWER 4'h3
`define TCA_SCR_RESIDUAL 4'h6
`define TCA_SCR_PER_DEGREE 4'h7
`define TCA_SCR_CHECK 4'h8

// Values
`define TCA_TEMP_POR 16'h00aa
`define TCA_COUNTS_PER_DEGREE 8'h10
`define TCA_RESERVED_BYTE 8'hff
`define TCA_CRC_POLY 8'h8c
`define TCA_SCR_DATA_BITS 64
`define TCA_ROM_DATA_BITS 56
`define TCA_LAST_BIT 3'h7
`define TCA_LAST_ROM_BIT 6'h3f

// Nonvolatile write time
`define TCA_NV_WRITE_TIME_US 10000
`define TCA_CLK_MHZ 250
`define TCA_NV_WRITE_CYCLES (`TCA_NV_WRITE_TIME_US * `TCA_CLK_MHZ)

`endif

// >>> design/tca_pkg.sv
// Types for the temperature conversion and alarm core
package tca_pkg;

   typedef enum logic [3:0] {
      ST_IDLE,
      ST_ADDR_CMD,
      ST_FUNC_CMD,
      ST_SEARCH,
      ST_TX_SCR,
      ST_RX_SCR,
      ST_POLL,
      ST_SUPPLY
   } tca_state_t;

   typedef struct packed {
      logic [8:0] temp;
      logic [7:0] residual;
   } tca_conv_t;

   typedef struct packed {
      logic [7:0] upper;
      logic [7:0] lower;
   } tca_limits_t;

   typedef struct packed {
      tca_state_t state;
      logic [7:0] rxShift;
      logic [2:0] bitCnt;
      logic [3:0] byteIdx;
      logic [5:0] srchIdx;
      logic [1:0] srchPhase;
      logic dqOe;
      logic [15:0] temp;
      logic [7:0] residual;
      tca_limits_t limits;
      tca_limits_t nvOut;
      logic alarm;
      logic convBusy;
      logic convStart;
      logic copyBusy;
      logic [21:0] copyCnt;
      logic nvWr;
      logic loadPend;
      logic extPwrMeta;
      logic extPwr;
   } tca_regs_t;

endpackage

// >>> design/tca_core.sv
// Temperature conversion, alarm and bus command core
//
// How it works
// - Result has nine bits, half degree steps
// - Idle until start-conversion command arrives
// - Store finished result, then return idle
// - Read slots answer 0 busy, 1 done
// - Result is sign-extended 16-bit two's complement
// - Power-on result value is plus 85 degrees
// - Counts-per-degree always reads sixteen
// - Compare result with signed byte limits
// - Compare only result bits 8 to 1
// - Alarm when at/below lower or above upper
// - Alarm re-evaluated after every conversion
// - Limits nonvolatile, scratchpad bytes two, three
// - Only alarmed devices join alarm scan
// - Supply query: parasite pulls low, external releases
// - Identity: family byte, then 48-bit serial
// - Top identity byte is check over 56 bits
// - All bytes travel least significant bit first
// - Result low byte position zero, high one
// - Residual at position six, per-degree seven
// - Check bytes use x8+x5+x4+1, LSB first
`timescale 1ns/100ps
`include "tca_defs.svh"

module tca_core import tca_pkg::*; #(
   parameter int NV_WRITE_CYCLES = `TCA_NV_WRITE_CYCLES,
   // Arbitrary identity values
   parameter logic [47:0] SERIAL_NUMBER = 48'h0000_0000_0001,
   parameter logic [7:0] FAMILY_CODE = 8'h5a
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic busReset,
   input wire logic wrStrobe,
   input wire logic wrBit,
   input wire logic readSlot,
   input wire logic slotEnd,
   input wire logic dqIn,
   output logic dqOut,
   output logic dqOe,
   input wire logic extPowerPin,
   output logic convStart,
   input wire logic convDone,
   input wire tca_conv_t convData,
   input wire tca_limits_t nvLimitsIn,
   output logic nvWrite,
   output tca_limits_t nvLimitsOut,
   output logic nvBusy,
   output logic [15:0] tempResult,
   output logic alarmFlag,
   output logic convBusy
);

   function automatic logic [7:0] crcCalc(input logic [63:0] data, input int nbits);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < 64; i++) begin
         if (i < nbits) begin
            fb = c[0] ^ data[i];
            c = {1'b0, c[7:1]};
            if (fb) begin
               c = c ^ `TCA_CRC_POLY;
            end
         end
      end
      return c;
   endfunction

   localparam logic [55:0] ROM_LOW = {SERIAL_NUMBER, FAMILY_CODE};
   localparam logic [63:0] ROM_CODE = {crcCalc({8'h00, ROM_LOW}, `TCA_ROM_DATA_BITS),
      ROM_LOW};

   localparam tca_regs_t REGS_RST = '{
      state: ST_IDLE,
      rxShift: 8'h00,
      bitCnt: 3'h0,
      byteIdx: 4'h0,
      srchIdx: 6'h00,
      srchPhase: 2'h0,
      dqOe: 1'b0,
      temp: `TCA_TEMP_POR,
      residual: 8'h00,
      limits: 16'h0000,
      nvOut: 16'h0000,
      alarm: 1'b0,
      convBusy: 1'b0,
      convStart: 1'b0,
      copyBusy: 1'b0,
      copyCnt: 22'h000000,
      nvWr: 1'b0,
      loadPend: 1'b1,
      extPwrMeta: 1'b0,
      extPwr: 1'b0
   };

   tca_regs_t r_ff;
   tca_regs_t nxt_r;
   logic [63:0] scrVec;
   logic [7:0] scrCheck;
   logic [7:0] txByte;
   logic romBit;
   logic answer;
   logic [7:0] rxByte;
   logic byteDone;

   // Scratchpad image, byte 0 in the low bits
   assign scrVec = {`TCA_COUNTS_PER_DEGREE, r_ff.residual,
      `TCA_RESERVED_BYTE, `TCA_RESERVED_BYTE,
      r_ff.limits.lower, r_ff.limits.upper,
      r_ff.temp};
   assign scrCheck = crcCalc(scrVec, `TCA_SCR_DATA_BITS);
   assign txByte = (r_ff.byteIdx == `TCA_SCR_CHECK) ? scrCheck :
      scrVec[r_ff.byteIdx[2:0] * 8 +: 8];
   assign romBit = ROM_CODE[r_ff.srchIdx];
   assign rxByte = {wrBit, r_ff.rxShift[7:1]};
   assign byteDone = (r_ff.bitCnt == `TCA_LAST_BIT);

   // Bit placed on the bus in a read slot; zero means pull low
   always_comb begin
      answer = 1'b1;
      unique case (r_ff.state)
         ST_TX_SCR: answer = txByte[r_ff.bitCnt];
         ST_POLL: answer = ~(r_ff.convBusy | r_ff.copyBusy);
         ST_SUPPLY: answer = r_ff.extPwr;
         ST_SEARCH: answer = (r_ff.srchPhase == 2'h0) ? romBit : ~romBit;
         ST_IDLE, ST_ADDR_CMD, ST_FUNC_CMD, ST_RX_SCR: answer = 1'b1;
         default: answer = 1'b1;
      endcase
   end

   always_comb begin
      nxt_r = r_ff;
      nxt_r.convStart = 1'b0;
      nxt_r.nvWr = 1'b0;
      // Supply sense comes from a pin; second stage is the only reader
      nxt_r.extPwrMeta = extPowerPin;
      nxt_r.extPwr = r_ff.extPwrMeta;

      // Limits come back from nonvolatile storage after power-up
      if (r_ff.loadPend) begin
         nxt_r.limits = nvLimitsIn;
         nxt_r.loadPend = 1'b0;
      end

      if (convDone && r_ff.convBusy) begin
         nxt_r.temp = {{7{convData.temp[8]}}, convData.temp};
         nxt_r.residual = convData.residual;
         nxt_r.alarm = ($signed(convData.temp[8:1]) <= $signed(r_ff.limits.lower)) ||
            ($signed(convData.temp[8:1]) > $signed(r_ff.limits.upper));
         nxt_r.convBusy = 1'b0;
      end

      if (r_ff.copyBusy) begin
         if (r_ff.copyCnt == 22'(NV_WRITE_CYCLES - 1)) begin
            nxt_r.copyBusy = 1'b0;
         end else begin
            nxt_r.copyCnt = 22'(r_ff.copyCnt + 22'h000001);
         end
      end

      if (slotEnd) begin
         nxt_r.dqOe = 1'b0;
      end

      if (busReset) begin
         // Bus reset aborts any transfer but not a running conversion
         nxt_r.state = ST_ADDR_CMD;
         nxt_r.bitCnt = 3'h0;
         nxt_r.dqOe = 1'b0;
      end else if (readSlot) begin
         nxt_r.dqOe = ~answer;
         unique case (r_ff.state)
            ST_TX_SCR: begin
               nxt_r.bitCnt = 3'(r_ff.bitCnt + 3'h1);
               if (byteDone) begin
                  nxt_r.byteIdx = 4'(r_ff.byteIdx + 4'h1);
                  if (r_ff.byteIdx == `TCA_SCR_CHECK) begin
                     nxt_r.state = ST_IDLE;
                  end
               end
            end
            ST_SEARCH: begin
               if (r_ff.srchPhase != 2'h2) begin
                  nxt_r.srchPhase = 2'(r_ff.srchPhase + 2'h1);
               end
            end
            default: begin
            end
         endcase
      end else if (wrStrobe) begin
         nxt_r.rxShift = rxByte;
         unique case (r_ff.state)
            ST_ADDR_CMD: begin
               nxt_r.bitCnt = 3'(r_ff.bitCnt + 3'h1);
               if (byteDone) begin
                  nxt_r.state = ST_IDLE;
                  if (rxByte == `TCA_CMD_SKIP_ADDR) begin
                     nxt_r.state = ST_FUNC_CMD;
                  end else if (rxByte == `TCA_CMD_ALARM_SCAN && r_ff.alarm) begin
                     nxt_r.state = ST_SEARCH;
                     nxt_r.srchIdx = 6'h00;
                     nxt_r.srchPhase = 2'h0;
                  end
               end
            end
            ST_FUNC_CMD: begin
               nxt_r.bitCnt = 3'(r_ff.bitCnt + 3'h1);
               if (byteDone) begin
                  nxt_r.state = ST_IDLE;
                  nxt_r.byteIdx = 4'h0;
                  unique case (rxByte)
                     `TCA_CMD_CONVERT: begin
                        nxt_r.state = ST_POLL;
                        if (!r_ff.convBusy || convDone) begin
                           nxt_r.convBusy = 1'b1;
                           nxt_r.convStart = 1'b1;
                        end
                     end
                     `TCA_CMD_SUPPLY_QUERY: nxt_r.state = ST_SUPPLY;
                     `TCA_CMD_READ_SCRATCH: nxt_r.state = ST_TX_SCR;
                     `TCA_CMD_WRITE_SCRATCH: nxt_r.state = ST_RX_SCR;
                     `TCA_CMD_COMMIT_NV: begin
                        nxt_r.state = ST_POLL;
                        nxt_r.copyBusy = 1'b1;
                        nxt_r.copyCnt = 22'h000000;
                        nxt_r.nvWr = 1'b1;
                        nxt_r.nvOut = r_ff.limits;
                     end
                     default: nxt_r.state = ST_IDLE;
                  endcase
               end
            end
            ST_RX_SCR: begin
               nxt_r.bitCnt = 3'(r_ff.bitCnt + 3'h1);
               if (byteDone) begin
                  // Byte 2 arrives first, then byte 3
                  if (r_ff.byteIdx == 4'h0) begin
                     nxt_r.limits.upper = rxByte;
                     nxt_r.byteIdx = 4'h1;
                  end else begin
                     nxt_r.limits.lower = rxByte;
                     nxt_r.state = ST_IDLE;
                  end
               end
            end
            ST_SEARCH: begin
               if (r_ff.srchPhase == 2'h2) begin
                  nxt_r.srchPhase = 2'h0;
                  if (wrBit != romBit) begin
                     nxt_r.state = ST_IDLE;
                  end else if (r_ff.srchIdx == `TCA_LAST_ROM_BIT) begin
                     nxt_r.state = ST_FUNC_CMD;
                     nxt_r.bitCnt = 3'h0;
                  end else begin
                     nxt_r.srchIdx = 6'(r_ff.srchIdx + 6'h01);
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         r_ff <= REGS_RST;
      end else if (clkEn) begin
         r_ff <= nxt_r;
      end
   end

   // Open drain: the pin only ever pulls low
   assign dqOut = 1'b0;
   assign dqOe = r_ff.dqOe;
   assign convStart = r_ff.convStart;
   assign nvWrite = r_ff.nvWr;
   assign nvLimitsOut = r_ff.nvOut;
   assign nvBusy = r_ff.copyBusy;
   assign tempResult = r_ff.temp;
   assign alarmFlag = r_ff.alarm;
   assign convBusy = r_ff.convBusy;

endmodule

// >>> dv/tca_core_asserts.sv
// Port checker for the conversion and alarm core
`timescale 1ns/100ps
module tca_core_asserts import tca_pkg::*; #(
   parameter int NV_WRITE_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clkEn,
   input wire logic slotEnd,
   input wire logic convDone,
   input wire tca_conv_t convData,
   input wire logic dqOut,
   input wire logic dqOe,
   input wire logic convStart,
   input wire logic nvWrite,
   input wire logic nvBusy,
   input wire logic [15:0] tempResult,
   input wire logic alarmFlag,
   input wire logic convBusy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   logic [31:0] busyRun_ff;
   // Counter keeps the long busy span out of the property unroll
   always_ff @(posedge sys_clk) begin
      busyRun_ff <= (sys_rst || !nvBusy) ? 32'h0 : busyRun_ff + 32'h1;
   end
   sequence convFinish;
      convBusy && convDone && clkEn;
   endsequence
   sequence resultLoaded;
      !convBusy && tempResult == {{7{$past(convData.temp[8])}}, $past(convData.temp)};
   endsequence
   reset_values_a: assert property (disable iff (1'b0)
      sys_rst |=> tempResult == 16'h00aa && !alarmFlag && !convBusy)
      else $error("reset values wrong");
   sign_extend_a: assert property (tempResult[15:9] == {7{tempResult[8]}})
      else $error("result not sign extended");
   result_load_a: assert property (convFinish |=> resultLoaded)
      else $error("finished result not stored");
   result_hold_a: assert property (!convFinish |=> $stable(tempResult))
      else $error("result changed without conversion");
   alarm_hold_a: assert property (!convFinish |=> $stable(alarmFlag))
      else $error("alarm changed without conversion");
   start_pulse_a: assert property (convStart |=> !convStart)
      else $error("start not a single pulse");
   nv_busy_a: assert property (nvWrite |=> nvBusy [*8])
      else $error("busy missing after commit");
   nv_busy_len_a: assert property (busyRun_ff <= NV_WRITE_CYCLES)
      else $error("busy too long");
   dq_release_a: assert property (slotEnd && clkEn |=> !dqOe)
      else $error("line held after slot end");
   open_drain_a: assert property (dqOut == 1'b0)
      else $error("line driven high");
endmodule

// >>> dv/tca_conv_model.sv
// Converter and nonvolatile limit store beside the core
`timescale 1ns/100ps
module tca_conv_model import tca_pkg::*; #(
   parameter int CONV_CYCLES = 40,
   parameter logic [15:0] NV_INIT = 16'h19f6,
   parameter logic [7:0] RESIDUAL = 8'h0c
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic convStart,
   input wire logic [8:0] nextTemp,
   input wire logic nvWrite,
   input wire tca_limits_t nvLimitsOut,
   output logic convDone,
   output tca_conv_t convData,
   output tca_limits_t nvLimitsIn
);
   int waitCnt = 0;
   tca_conv_t result = '0;
   // Store is not cleared by sys_rst: limits must survive a reset
   tca_limits_t nvStore = NV_INIT;
   initial convDone = 1'b0;
   // Inverted outside convDone so a stray sample is caught
   assign convData = convDone ? result : ~result;
   assign nvLimitsIn = nvStore;
   always @(posedge sys_clk) begin
      convDone <= 1'b0;
      if (sys_rst) begin
         waitCnt <= 0;
      end else if (convStart) begin
         waitCnt <= CONV_CYCLES;
         result <= '{temp: nextTemp, residual: RESIDUAL};
      end else if (waitCnt == 1) begin
         waitCnt <= 0;
         convDone <= 1'b1;
      end else if (waitCnt > 1) begin
         waitCnt <= waitCnt - 1;
      end
      if (nvWrite) begin
         nvStore <= nvLimitsOut;
      end
   end
endmodule

// >>> dv/test_tca_core.sv
// Self-checking bench for the conversion and alarm core
`timescale 1ns/100ps
`include "tca_defs.svh"
module test_tca_core import tca_pkg::*; ;
   logic sys_clk = 0, sys_rst = 1, clkEn = 1, busReset = 0, wrStrobe = 0, wrBit = 0;
   logic readSlot = 0, slotEnd = 0, extPowerPin = 0, dqOut, dqOe, convStart, convDone;
   logic nvWrite, nvBusy, alarmFlag, convBusy, rdBit;
   logic [15:0] tempResult;
   logic [8:0] nextTemp = 9'h000;
   logic [7:0] rdByte;
   tca_conv_t convData;
   tca_limits_t nvLimitsIn, nvLimitsOut;
   int badCount = 0, totalChecks = 0;
   logic [8:0] temps [4] = '{9'h032, 9'h035, 9'h1ec, 9'h1ef};
   logic [7:0] scr [8] = '{8'h01, 8'h00, 8'h05, 8'h00, 8'hff, 8'hff, 8'h0c, 8'h10};
   logic [71:0] scrGot;
   logic [63:0] romGot, romInv;
   // Arbitrary identity values, passed to the core so the bench owns them
   localparam logic [47:0] SERIAL = 48'h0000_00a5_1c3e;
   localparam logic [7:0] FAMILY = 8'h3c;
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   tca_core #(.NV_WRITE_CYCLES(20), .SERIAL_NUMBER(SERIAL), .FAMILY_CODE(FAMILY))
      tca_core_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clkEn(clkEn), .busReset(busReset), .wrStrobe(wrStrobe), .wrBit(wrBit),
      .readSlot(readSlot), .slotEnd(slotEnd), .dqIn(~dqOe), .dqOut(dqOut), .dqOe(dqOe),
      .extPowerPin(extPowerPin), .convStart(convStart), .convDone(convDone),
      .convData(convData), .nvLimitsIn(nvLimitsIn), .nvWrite(nvWrite),
      .nvLimitsOut(nvLimitsOut), .nvBusy(nvBusy), .tempResult(tempResult),
      .alarmFlag(alarmFlag), .convBusy(convBusy));
   tca_conv_model tca_conv_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .convStart(convStart), .nextTemp(nextTemp), .nvWrite(nvWrite),
      .nvLimitsOut(nvLimitsOut), .convDone(convDone), .convData(convData),
      .nvLimitsIn(nvLimitsIn));
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic testDone();
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic sendBit(input logic v);
      @(posedge sys_clk);
      wrStrobe <= 1'b1;
      wrBit <= v;
      @(posedge sys_clk);
      wrStrobe <= 1'b0;
   endtask
   task automatic sendByte(input logic [7:0] v);
      for (int i = 0; i < 8; i++) sendBit(v[i]);
   endtask
   // Shift register form of x8+x5+x4+1; a good stream followed by its check gives zero
   function automatic logic [7:0] crcOf(input logic [71:0] d, input int n);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 0; i < 72; i++) begin
         if (i < n) begin
            fb = c[0] ^ d[i];
            c = {fb, c[7:5], c[4] ^ fb, c[3] ^ fb, c[2:1]};
         end
      end
      return c;
   endfunction
   // Scan: per identity bit a read, a complement read, then the bit written back
   task automatic alarmScan(output logic [63:0] rom, output logic [63:0] inv);
      @(posedge sys_clk);
      busReset <= 1'b1;
      @(posedge sys_clk);
      busReset <= 1'b0;
      sendByte(`TCA_CMD_ALARM_SCAN);
      for (int i = 0; i < 64; i++) begin
         readBit(rom[i]);
         readBit(inv[i]);
         sendBit(rom[i]);
      end
   endtask
   task automatic command(input logic [7:0] f);
      @(posedge sys_clk);
      busReset <= 1'b1;
      @(posedge sys_clk);
      busReset <= 1'b0;
      sendByte(`TCA_CMD_SKIP_ADDR);
      sendByte(f);
   endtask
   // Line level is the pull-up unless the core pulls low
   task automatic readBit(output logic b);
      @(posedge sys_clk);
      readSlot <= 1'b1;
      @(posedge sys_clk);
      readSlot <= 1'b0;
      @(negedge sys_clk);
      b = ~dqOe;
      @(posedge sys_clk);
      slotEnd <= 1'b1;
      @(posedge sys_clk);
      slotEnd <= 1'b0;
   endtask
   function automatic logic alarmOf(input logic [8:0] t, input logic [7:0] up,
      input logic [7:0] lo);
      return $signed(t[8:1]) <= $signed(lo) || $signed(t[8:1]) > $signed(up);
   endfunction
   task automatic convert(input logic [8:0] t, input logic [7:0] up, input logic [7:0] lo);
      @(posedge sys_clk);
      nextTemp <= t;
      command(`TCA_CMD_CONVERT);
      readBit(rdBit);
      check(rdBit, 1'b0, "busy answer");
      for (int n = 0; n < 200 && convBusy !== 1'b0; n++) @(negedge sys_clk);
      check(tempResult, {{7{t[8]}}, t}, "result");
      check(alarmFlag, alarmOf(t, up, lo), "alarm");
      readBit(rdBit);
      check(rdBit, 1'b1, "done answer");
   endtask
   initial begin
      repeat (30000) @(posedge sys_clk);
      badCount++;
      $display("mismatch at %0t: watchdog expired", $time);
      testDone();
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      check(tempResult, 16'h00aa, "reset result");
      check(alarmFlag, 1'b0, "reset alarm");
      $display("test reset done");
      alarmScan(romGot, romInv);
      check(romGot[15:0], 16'hffff, "scan refused");
      for (int p = 0; p < 2; p++) begin
         extPowerPin <= p[0];
         repeat (3) @(posedge sys_clk);
         command(`TCA_CMD_SUPPLY_QUERY);
         readBit(rdBit);
         check(rdBit, p[0], "supply answer");
      end
      $display("test supply done");
      for (int k = 0; k < 4; k++) convert(temps[k], 8'h19, 8'hf6);
      $display("test convert done");
      command(`TCA_CMD_WRITE_SCRATCH);
      sendByte(8'h05);
      sendByte(8'h00);
      convert(9'h001, 8'h05, 8'h00);
      alarmScan(romGot, romInv);
      check(romGot[7:0], FAMILY, "family byte");
      check(romGot[23:8], SERIAL[15:0], "serial low");
      check(romGot[39:24], SERIAL[31:16], "serial mid");
      check(romGot[55:40], SERIAL[47:32], "serial high");
      check(crcOf({8'h00, romGot}, 64), 8'h00, "identity check byte");
      check(&(romGot ^ romInv), 1'b1, "scan complements");
      $display("test scan done");
      command(`TCA_CMD_COMMIT_NV);
      for (int n = 0; n < 50 && nvWrite !== 1'b1; n++) @(negedge sys_clk);
      check(nvLimitsOut, 16'h0500, "committed limits");
      for (int n = 0; n < 50 && nvBusy !== 1'b0; n++) @(negedge sys_clk);
      $display("test commit done");
      command(`TCA_CMD_READ_SCRATCH);
      for (int b = 0; b < 9; b++) begin
         readByte(rdByte);
         scrGot[b * 8 +: 8] = rdByte;
         if (b < 8) check(rdByte, scr[b], "scratch byte");
      end
      check(crcOf(scrGot, 72), 8'h00, "scratch check byte");
      $display("test scratch done");
      testDone();
   end
   task automatic readByte(output logic [7:0] v);
      for (int i = 0; i < 8; i++) readBit(v[i]);
   endtask
endmodule
bind tca_core tca_core_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk_inst (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .clkEn(clkEn), .slotEnd(slotEnd),
   .convDone(convDone), .convData(convData), .dqOut(dqOut), .dqOe(dqOe),
   .convStart(convStart), .nvWrite(nvWrite), .nvBusy(nvBusy), .tempResult(tempResult),
   .alarmFlag(alarmFlag), .convBusy(convBusy));
